// ### verilog/mcd_pkg.sv
// Package for the motion module command decoder: frame layout, codes, counts.
// Assumes one clock domain and a byte-wide frame stream from the host.
`default_nettype none
package mcd_pkg;
  // -----------------------------------------------------------------
  // Frame layout
  // -----------------------------------------------------------------
  localparam int          FRAME_BYTES   = 9;
  localparam logic [3:0]  IDX_ADDR      = 4'h0;
  localparam logic [3:0]  IDX_INSTR     = 4'h1;
  localparam logic [3:0]  IDX_TYPE      = 4'h2;
  localparam logic [3:0]  IDX_BANK      = 4'h3;
  localparam logic [3:0]  IDX_VAL3      = 4'h4;
  localparam logic [3:0]  IDX_VAL0      = 4'h7;
  localparam logic [3:0]  IDX_CSUM      = 4'h8;
  localparam logic [3:0]  REPLY_LAST    = 4'h8;
  // -----------------------------------------------------------------
  // Codes
  // -----------------------------------------------------------------
  localparam logic [7:0]  INS_STORE     = 8'h0b;
  localparam logic [7:0]  INS_RESTORE   = 8'h0c;
  localparam logic [7:0]  INS_REFSRCH   = 8'h0d;
  localparam logic [7:0]  INS_SETOUT    = 8'h0e;
  localparam logic [7:0]  BANK_GLOBAL   = 8'h00;
  localparam logic [7:0]  BANK_USER     = 8'h02;
  localparam logic [7:0]  RFS_START     = 8'h00;
  localparam logic [7:0]  RFS_STOP      = 8'h01;
  localparam logic [7:0]  RFS_STATUS    = 8'h02;
  localparam logic [7:0]  PORT_ALL      = 8'hff;
  localparam logic [31:0] VAL_FROM_ACC  = 32'hffffffff;
  localparam logic [7:0]  ST_OK         = 8'h64;
  localparam logic [7:0]  ST_BAD_CSUM   = 8'h01;
  localparam logic [7:0]  ST_BAD_CMD    = 8'h02;
  localparam logic [7:0]  ST_BAD_TYPE   = 8'h03;
  localparam logic [7:0]  ST_BAD_VALUE  = 8'h04;
  // -----------------------------------------------------------------
  // Sizes and reset values
  // -----------------------------------------------------------------
  localparam int          VAR_AW        = 8;
  localparam int          NUM_OUTS      = 1;
  localparam logic [7:0]  HOST_ADDR_RST = 8'h02;
  localparam logic [7:0]  MOD_ADDR_RST  = 8'h01;
  localparam logic [0:0]  OUT_RST       = 1'h0;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  ptype;
    logic [7:0]  bank;
    logic [31:0] value;
  } mcd_cmd_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  index;
    logic [31:0] data;
  } mcd_nvreq_s;
endpackage : mcd_pkg
`default_nettype wire

// ### verilog/mcd_var_mem.sv
// User variable store: one write port, one read port, registered read data.
// Assumes the caller holds the read address for one cycle before using data.
`default_nettype none
module mcd_var_mem
  import mcd_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              we,
  input  wire logic [VAR_AW-1:0] waddr,
  input  wire logic [31:0]       wdata,
  input  wire logic [VAR_AW-1:0] raddr,
  output var  logic [31:0]       rdata
);
  logic [31:0] mem [0:(1<<VAR_AW)-1];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // mcd_var_mem
`default_nettype wire

// ### verilog/mcd_reply_ser.sv
// Reply serialiser: sends nine bytes with a running modulo-256 checksum.
// Assumes the sink may stall by holding tx_ready low.
`default_nettype none
module mcd_reply_ser
  import mcd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] mod_addr,
  input  wire logic [7:0] status,
  input  wire logic [7:0] instr,
  input  wire logic [31:0] value,
  output var  logic       busy,
  output var  logic [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready
);
  logic [71:0] shift_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sum_r;
  logic        act_r;
  wire  logic  fire = act_r & tx_ready;
  wire  logic  last = (cnt_r == REPLY_LAST);
  wire  logic [7:0] head = shift_r[71:64];

  assign tx_valid = act_r;
  assign busy     = act_r;
  assign tx_data  = last ? sum_r : head;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_r   <= 1'b0;
      cnt_r   <= 4'h0;
      sum_r   <= 8'h00;
      shift_r <= '0;
    end else if (start && !act_r) begin
      act_r   <= 1'b1;
      cnt_r   <= 4'h0;
      sum_r   <= 8'h00;
      shift_r <= {host_addr, mod_addr, status, instr, value, 8'h00};
    end else if (fire) begin
      sum_r   <= sum_r + head;
      shift_r <= {shift_r[63:0], 8'h00};
      cnt_r   <= cnt_r + 4'h1;
      act_r   <= !last;
    end
  end
endmodule // mcd_reply_ser
`default_nettype wire

// ### verilog/mcd_decoder.sv
// Command decoder top: frame receiver, command execution, reply start.
// Assumes byte stream from a host UART/CAN front end on ref_clk.
// How it works
// - Store opcode, bank two: variable to store.
// - Bank zero parameter writes persist automatically; code ignores them in boot and drops one in a command store's issue cycle.
// - After reset, reload all variables from store.
// - Restore opcode, bank two: reload one variable.
// - Frame: addr, instr, type, bank, value, checksum.
// - These commands reply status 100, value zero.
// - Opcode 13: start, stop, query reference search.
// - Query replies zero idle, nonzero while searching.
// - Set-output opcode drives selected line to value.
// - Single output line, port zero, one is high.
// - Port 255 writes all outputs from bit vector.
// - Value minus one takes vector from accumulator.
// - Reply: host, target, status, instr, value, checksum.
`default_nettype none
module mcd_decoder
  import mcd_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [7:0]          rx_data,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  output var  logic [7:0]          tx_data,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  input  wire logic [31:0]         accumulator,
  input  wire logic                gp_param_wr,
  input  wire logic [7:0]          gp_param_idx,
  input  wire logic [31:0]         gp_param_data,
  input  wire logic                gp_param_volatile,
  output var  mcd_nvreq_s          nv_store,
  output var  mcd_nvreq_s          nv_load,
  input  wire logic                nv_load_done,
  input  wire logic [31:0]         nv_load_data,
  input  wire logic                nv_store_done,
  output var  logic                ref_start,
  output var  logic                ref_stop,
  input  wire logic                ref_active,
  output var  logic [NUM_OUTS-1:0] general_output_zero,
  output var  logic [31:0]         user_var_rdata,
  input  wire logic [VAR_AW-1:0]   user_var_raddr
);
  // -----------------------------------------------------------------
  // States
  // -----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_BOOT  = 6'b000001,
    S_RX    = 6'b000010,
    S_EXEC  = 6'b000100,
    S_NVWT  = 6'b001000,
    S_REPLY = 6'b010000,
    S_DRAIN = 6'b100000
  } mcd_state_e;

  mcd_state_e  state_r, state_nxt;
  logic [3:0]  idx_r;
  logic [7:0]  sum_r;
  mcd_cmd_s    cmd_r;
  logic        csum_ok_r;
  logic [7:0]  status_r;
  logic [31:0] rvalue_r;
  logic [VAR_AW:0] boot_r;
  logic        boot_wait_r;
  logic        nv_store_pend_r;
  logic        nv_load_pend_r;
  logic        ser_busy;
  logic        store_arm_r;

  // -----------------------------------------------------------------
  // Frame receive
  // -----------------------------------------------------------------
  wire logic       rx_take   = rx_valid & rx_ready;
  wire logic       rx_last   = (idx_r == IDX_CSUM);
  assign rx_ready = (state_r == S_RX);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idx_r     <= 4'h0;
      sum_r     <= 8'h00;
      cmd_r     <= '0;
      csum_ok_r <= 1'b0;
    end else if (rx_take) begin
      idx_r <= rx_last ? 4'h0 : idx_r + 4'h1;
      sum_r <= rx_last ? 8'h00 : sum_r + rx_data;
      unique case (idx_r)
        IDX_ADDR:  cmd_r.addr  <= rx_data;
        IDX_INSTR: cmd_r.instr <= rx_data;
        IDX_TYPE:  cmd_r.ptype <= rx_data;
        IDX_BANK:  cmd_r.bank  <= rx_data;
        IDX_CSUM:  csum_ok_r   <= (rx_data == sum_r);
        default:   cmd_r.value <= {cmd_r.value[23:0], rx_data};
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  wire logic is_store   = (cmd_r.instr == INS_STORE);
  wire logic is_restore = (cmd_r.instr == INS_RESTORE);
  wire logic is_ref     = (cmd_r.instr == INS_REFSRCH);
  wire logic is_setout  = (cmd_r.instr == INS_SETOUT);
  wire logic bank_user  = (cmd_r.bank == BANK_USER);
  wire logic port_all   = (cmd_r.ptype == PORT_ALL);
  wire logic val_acc    = (cmd_r.value == VAL_FROM_ACC);
  wire logic port_ok    = (cmd_r.ptype < NUM_OUTS) | port_all;
  wire logic ref_type_ok = (cmd_r.ptype <= RFS_STATUS) & (cmd_r.bank == BANK_GLOBAL);
  wire logic bit_ok     = (cmd_r.value[31:1] == 31'h0);
  wire logic [31:0] out_vec = val_acc ? accumulator : cmd_r.value;
  wire logic [VAR_AW-1:0] var_idx = cmd_r.ptype[VAR_AW-1:0];

  logic [7:0] exec_status;
  always_comb begin
    exec_status = ST_OK;
    if (!csum_ok_r) begin
      exec_status = ST_BAD_CSUM;
    end else if ((is_store || is_restore) && !bank_user) begin
      exec_status = ST_BAD_TYPE;
    end else if (is_ref && !ref_type_ok) begin
      exec_status = ST_BAD_TYPE;
    end else if (is_setout && (!bank_user || !port_ok)) begin
      exec_status = ST_BAD_TYPE;
    end else if (is_setout && !port_all && !bit_ok) begin
      exec_status = ST_BAD_VALUE;
    end else if (!(is_store || is_restore || is_ref || is_setout)) begin
      exec_status = ST_BAD_CMD;
    end
  end
  wire logic exec_ok  = (exec_status == ST_OK);
  wire logic do_nv    = exec_ok & (is_store | is_restore);

  // -----------------------------------------------------------------
  // User variables
  // -----------------------------------------------------------------
  wire logic [VAR_AW-1:0] boot_idx = boot_r[VAR_AW-1:0];
  wire logic              boot_end = boot_r[VAR_AW];
  wire logic mem_we_boot  = (state_r == S_BOOT) & boot_wait_r & nv_load_done;
  wire logic mem_we_rst   = (state_r == S_NVWT) & nv_load_pend_r & nv_load_done;
  wire logic mem_we_host  = gp_param_wr & ~(state_r == S_BOOT);
  wire logic mem_we       = mem_we_boot | mem_we_rst | mem_we_host;
  wire logic [VAR_AW-1:0] mem_waddr = mem_we_boot ? boot_idx :
                                      mem_we_rst  ? var_idx  : gp_param_idx[VAR_AW-1:0];
  wire logic [31:0] mem_wdata = (mem_we_boot | mem_we_rst) ? nv_load_data : gp_param_data;
  wire logic [VAR_AW-1:0] mem_raddr = (state_r == S_EXEC) ? var_idx : user_var_raddr;
  logic [31:0] mem_rdata;

  mcd_var_mem u_mem (
    .ref_clk (ref_clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );
  assign user_var_rdata = mem_rdata;

  // -----------------------------------------------------------------
  // Automatic persist
  // -----------------------------------------------------------------
  // Bank zero writes go to the store as soon as they land, unless volatile or a command store issues in the same cycle
  wire logic auto_store = gp_param_wr & ~gp_param_volatile & ~(state_r == S_BOOT);

  // -----------------------------------------------------------------
  // Control
  // -----------------------------------------------------------------
  // Hold in NVWT until the store is issued and every done pulse is back
  wire logic nv_pend = nv_store_pend_r | nv_load_pend_r | store_arm_r;
  wire logic nv_idle = ~nv_pend & ~nv_store.valid & ~nv_load.valid;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_BOOT:  if (boot_end) state_nxt = S_RX;
      S_RX:    if (rx_take && rx_last) state_nxt = S_EXEC;
      S_EXEC:  state_nxt = do_nv ? S_NVWT : S_REPLY;
      S_NVWT: begin
        if (nv_idle) begin
          state_nxt = S_REPLY;
        end
      end
      S_REPLY: state_nxt = S_DRAIN;
      S_DRAIN: if (!ser_busy) state_nxt = S_RX;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= S_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Boot reload
  // -----------------------------------------------------------------
  // Walk over every variable index
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      boot_r      <= '0;
      boot_wait_r <= 1'b0;
    end else if (state_r == S_BOOT && !boot_end) begin
      if (!boot_wait_r) begin
        boot_wait_r <= 1'b1;
      end else if (nv_load_done) begin
        boot_wait_r <= 1'b0;
        boot_r      <= boot_r + 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Command execution
  // -----------------------------------------------------------------
  wire logic store_cmd = (state_r == S_EXEC) & exec_ok & is_store;
  wire logic load_cmd  = (state_r == S_EXEC) & exec_ok & is_restore;
  wire logic boot_req  = (state_r == S_BOOT) & ~boot_end & ~boot_wait_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nv_store        <= '0;
      nv_load         <= '0;
      nv_store_pend_r <= 1'b0;
      nv_load_pend_r  <= 1'b0;
      status_r        <= ST_OK;
      rvalue_r        <= 32'h0;
      ref_start       <= 1'b0;
      ref_stop        <= 1'b0;
      general_output_zero <= {NUM_OUTS{OUT_RST}};
    end else begin
      nv_store.valid <= 1'b0;
      nv_load.valid  <= 1'b0;
      ref_start      <= 1'b0;
      ref_stop       <= 1'b0;
      if (nv_store_done) nv_store_pend_r <= 1'b0;
      if (nv_load_done)  nv_load_pend_r  <= 1'b0;
      if (auto_store) begin
        nv_store <= '{valid: 1'b1, index: gp_param_idx, data: gp_param_data};
      end
      if (state_r == S_NVWT && store_arm_r) begin
        nv_store <= '{valid: 1'b1, index: cmd_r.ptype, data: mem_rdata};
        nv_store_pend_r <= 1'b1;
      end
      if (boot_req) begin
        nv_load <= '{valid: 1'b1, index: boot_idx, data: 32'h0};
      end
      if (load_cmd) begin
        nv_load <= '{valid: 1'b1, index: cmd_r.ptype, data: 32'h0};
        nv_load_pend_r <= 1'b1;
      end
      if (state_r == S_EXEC) begin
        status_r <= exec_status;
        rvalue_r <= 32'h0;
        if (exec_ok && is_ref) begin
          ref_start <= (cmd_r.ptype == RFS_START);
          ref_stop  <= (cmd_r.ptype == RFS_STOP);
          if (cmd_r.ptype == RFS_STATUS) begin
            rvalue_r <= {31'h0, ref_active};
          end
        end
        if (exec_ok && is_setout) begin
          if (port_all) begin
            general_output_zero <= out_vec[NUM_OUTS-1:0];
          end else begin
            general_output_zero[0] <= cmd_r.value[0];
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Store data arm
  // -----------------------------------------------------------------
  // Store data is read one cycle after EXEC, so issue it on entry to NVWT
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      store_arm_r <= 1'b0;
    end else begin
      store_arm_r <= store_cmd;
    end
  end

  // -----------------------------------------------------------------
  // Reply
  // -----------------------------------------------------------------
  mcd_reply_ser u_ser (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     (state_r == S_REPLY),
    .host_addr (HOST_ADDR_RST),
    .mod_addr  (MOD_ADDR_RST),
    .status    (status_r),
    .instr     (cmd_r.instr),
    .value     (rvalue_r),
    .busy      (ser_busy),
    .tx_data   (tx_data),
    .tx_valid  (tx_valid),
    .tx_ready  (tx_ready)
  );
endmodule // mcd_decoder
`default_nettype wire

// ### bench/mcd_assertions.sv
// Port checker for the command decoder.
// Bound to mcd_decoder from the bench top; sees its ports only.
`default_nettype none
module mcd_assertions
  import mcd_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       gp_param_wr,
  input wire logic       gp_param_volatile,
  input wire mcd_nvreq_s nv_store,
  input wire mcd_nvreq_s nv_load,
  input wire logic       ref_start,
  input wire logic       ref_stop,
  input wire logic [0:0] general_output_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------
  // Frame byte counter
  // ---------------------------------------------
  logic [3:0] cnt_r;
  always_ff @(posedge ref_clk) begin
    if (rst)
      cnt_r <= 4'h0;
    else if (rx_valid && rx_ready)
      cnt_r <= (cnt_r == IDX_CSUM) ? 4'h0 : cnt_r + 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_last;
    rx_valid && rx_ready && cnt_r == IDX_CSUM;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  a_reply_gap: assert property (s_last |=> !tx_valid [*2])
    else $error("reply started too early");
  a_rx_closed: assert property (tx_valid |-> !rx_ready)
    else $error("frame accepted while replying");
  a_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
    else $error("reply byte lost under stall");
  a_auto_store: assert property (gp_param_wr && !gp_param_volatile |-> ##[1:4] nv_store.valid)
    else $error("parameter write not persisted");
  a_store_pulse: assert property (nv_store.valid |=> !nv_store.valid)
    else $error("store request longer than one cycle");
  a_load_pulse: assert property (nv_load.valid |-> nv_load.data == 32'h0 ##1 !nv_load.valid)
    else $error("load request malformed");
  a_ref_pulse: assert property (ref_start || ref_stop |-> ref_start != ref_stop ##1 !(ref_start || ref_stop))
    else $error("search control pulse malformed");
  a_out_quiet: assert property (!$stable(general_output_zero) |-> !rx_ready)
    else $error("output moved outside command execution");
  a_out_reset: assert property (disable iff (1'b0) rst |=> general_output_zero == 1'h0)
    else $error("output not low after reset");
endmodule // mcd_assertions
`default_nettype wire

// ### bench/mcd_nv_model.sv
// Model of the nonvolatile store and the reference-search machine.
// Answers each load and store request unless another of the same kind arrives before its done pulse; slow adds wait cycles.
`default_nettype none
module mcd_nv_model
  import mcd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire mcd_nvreq_s  nv_store,
  input  wire mcd_nvreq_s  nv_load,
  output var  logic        nv_load_done,
  output var  logic [31:0] nv_load_data,
  output var  logic        nv_store_done,
  input  wire logic        ref_start,
  input  wire logic        ref_stop,
  output var  logic        ref_active
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [256];
  logic [7:0]  ld_idx_r;
  logic [2:0]  ld_wait_r;
  logic [2:0]  st_wait_r;
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'ha5c30000 | 32'(i);
  end
  always @(posedge ref_clk) begin
    nv_load_done <= 1'b0;
    nv_store_done <= 1'b0;
    // Data line toggles while no answer is held
    nv_load_data <= ~nv_load_data;
    if (rst) begin
      nv_load_data <= 32'h0;
      ld_wait_r <= 3'h0;
      st_wait_r <= 3'h0;
      ref_active <= 1'b0;
    end else begin
      if (nv_load.valid) begin
        ld_idx_r <= nv_load.index;
        ld_wait_r <= slow ? 3'h5 : 3'h1;
      end else if (ld_wait_r == 3'h1) begin
        nv_load_done <= 1'b1;
        nv_load_data <= mem[ld_idx_r];
        ld_wait_r <= 3'h0;
      end else if (ld_wait_r != 3'h0)
        ld_wait_r <= ld_wait_r - 3'h1;
      if (nv_store.valid) begin
        mem[nv_store.index] <= nv_store.data;
        st_wait_r <= slow ? 3'h5 : 3'h1;
      end else if (st_wait_r == 3'h1) begin
        nv_store_done <= 1'b1;
        st_wait_r <= 3'h0;
      end else if (st_wait_r != 3'h0)
        st_wait_r <= st_wait_r - 3'h1;
      if (ref_start)
        ref_active <= 1'b1;
      else if (ref_stop)
        ref_active <= 1'b0;
    end
  end
endmodule // mcd_nv_model
`default_nettype wire

// ### bench/mcd_decoder_tb.sv
// Self-checking bench for mcd_decoder.
// Host side driven by tasks; far side by mcd_nv_model.
`default_nettype none
module mcd_decoder_tb
  import mcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, tx_ready = 1'b0, slow = 1'b0;
  logic gp_param_wr = 1'b0, gp_param_volatile = 1'b0;
  logic [7:0] rx_data = 8'h0, gp_param_idx = 8'h0, user_var_raddr = 8'h0, tx_data;
  logic [31:0] accumulator = 32'h0, gp_param_data = 32'h0, nv_load_data, user_var_rdata;
  logic rx_ready, tx_valid, nv_load_done, nv_store_done, ref_start, ref_stop, ref_active;
  logic [0:0] general_output_zero;
  mcd_nvreq_s nv_store, nv_load;
  int n_mismatch = 0, checked = 0, cyc = 0;
  mcd_decoder dut (.ref_clk(ref_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .accumulator(accumulator), .gp_param_wr(gp_param_wr), .gp_param_idx(gp_param_idx),
    .gp_param_data(gp_param_data), .gp_param_volatile(gp_param_volatile),
    .nv_store(nv_store), .nv_load(nv_load), .nv_load_done(nv_load_done),
    .nv_load_data(nv_load_data), .nv_store_done(nv_store_done), .ref_start(ref_start),
    .ref_stop(ref_stop), .ref_active(ref_active), .general_output_zero(general_output_zero),
    .user_var_rdata(user_var_rdata), .user_var_raddr(user_var_raddr));
  mcd_nv_model nvm (.ref_clk(ref_clk), .rst(rst), .slow(slow), .nv_store(nv_store),
    .nv_load(nv_load), .nv_load_done(nv_load_done), .nv_load_data(nv_load_data),
    .nv_store_done(nv_store_done), .ref_start(ref_start), .ref_stop(ref_stop),
    .ref_active(ref_active));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bnk,
                      input logic [31:0] val, input logic [7:0] st, input logic [31:0] rv,
                      input bit bad);
    logic [7:0] f [9];
    logic [7:0] r [9];
    int n;
    f = '{MOD_ADDR_RST, ins, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h0};
    r = '{HOST_ADDR_RST, MOD_ADDR_RST, st, ins, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h0};
    for (int i = 0; i < 8; i++) begin
      f[8] += f[i];
      r[8] += r[i];
    end
    if (bad)
      f[8] += 8'h01;
    for (int i = 0; i < 9; i++) begin
      @(negedge ref_clk);
      rx_data = f[i];
      rx_valid = 1'b1;
      for (n = 0; rx_ready !== 1'b1 && n < 2000; n++)
        @(negedge ref_clk);
      if (n == 2000) n_mismatch++;
    end
    for (int i = 0; i < 9; i++) begin
      n = 0;
      do begin
        @(negedge ref_clk);
        rx_valid = 1'b0;
        tx_ready = !(i % 2 == 1 && n == 0);
        n++;
      end while (!(tx_valid === 1'b1 && tx_ready) && n < 2000);
      check({24'h0, tx_data}, {24'h0, r[i]});
    end
    @(negedge ref_clk);
    tx_ready = 1'b0;
  endtask
  task automatic read_var(input logic [7:0] idx, input logic [31:0] exp);
    @(negedge ref_clk);
    user_var_raddr = idx;
    repeat (2) @(negedge ref_clk);
    check(user_var_rdata, exp);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_outputs();
    xfer(INS_SETOUT, 8'h00, BANK_USER, 32'h1, ST_OK, 32'h0, 0);
    check(32'(general_output_zero), 32'h1);
    xfer(INS_SETOUT, 8'h00, BANK_USER, 32'h0, ST_OK, 32'h0, 0);
    check(32'(general_output_zero), 32'h0);
    xfer(INS_SETOUT, PORT_ALL, BANK_USER, 32'h1, ST_OK, 32'h0, 0);
    check(32'(general_output_zero), 32'h1);
    accumulator = 32'hfffffffe;
    xfer(INS_SETOUT, PORT_ALL, BANK_USER, VAL_FROM_ACC, ST_OK, 32'h0, 0);
    check(32'(general_output_zero), 32'h0);
    accumulator = 32'h00000001;
    xfer(INS_SETOUT, PORT_ALL, BANK_USER, VAL_FROM_ACC, ST_OK, 32'h0, 0);
    check(32'(general_output_zero), 32'h1);
  endtask
  task automatic t_errors();
    xfer(INS_SETOUT, 8'h00, BANK_USER, 32'h0, ST_BAD_CSUM, 32'h0, 1);
    check(32'(general_output_zero), 32'h1);
    xfer(INS_SETOUT, 8'h00, BANK_USER, 32'h2, ST_BAD_VALUE, 32'h0, 0);
    xfer(8'h05, 8'h00, BANK_USER, 32'h0, ST_BAD_CMD, 32'h0, 0);
    xfer(INS_STORE, 8'h2a, BANK_GLOBAL, 32'h0, ST_BAD_TYPE, 32'h0, 0);
    xfer(INS_REFSRCH, RFS_START, 8'h01, 32'h0, ST_BAD_TYPE, 32'h0, 0);
    xfer(INS_REFSRCH, 8'h03, 8'h00, 32'h0, ST_BAD_TYPE, 32'h0, 0);
    xfer(INS_SETOUT, 8'h01, BANK_USER, 32'h0, ST_BAD_TYPE, 32'h0, 0);
    check(32'(general_output_zero), 32'h1);
  endtask
  task automatic t_refsearch();
    xfer(INS_REFSRCH, RFS_START, 8'h00, 32'h5, ST_OK, 32'h0, 0);
    xfer(INS_REFSRCH, RFS_STATUS, 8'h00, 32'h0, ST_OK, 32'h1, 0);
    xfer(INS_REFSRCH, RFS_STOP, 8'h00, 32'h0, ST_OK, 32'h0, 0);
    xfer(INS_REFSRCH, RFS_STATUS, 8'h00, 32'h0, ST_OK, 32'h0, 0);
  endtask
  task automatic t_nv();
    nvm.mem[42] = 32'h12345678;
    xfer(INS_RESTORE, 8'h2a, BANK_USER, 32'h0, ST_OK, 32'h0, 0);
    read_var(8'h2a, 32'h12345678);
    nvm.mem[42] = 32'h0;
    slow = 1'b1;
    xfer(INS_STORE, 8'h2a, BANK_USER, 32'h0, ST_OK, 32'h0, 0);
    slow = 1'b0;
    check(nvm.mem[42], 32'h12345678);
  endtask
  task automatic t_auto(input logic vol, input logic [7:0] idx, input logic [31:0] exp);
    @(negedge ref_clk);
    gp_param_wr = 1'b1;
    gp_param_idx = idx;
    gp_param_data = 32'hcafe0001;
    gp_param_volatile = vol;
    @(negedge ref_clk);
    gp_param_wr = 1'b0;
    repeat (8) @(negedge ref_clk);
    check(nvm.mem[idx], exp);
  endtask
  initial begin
    int n;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    for (n = 0; rx_ready !== 1'b1 && n < 5000; n++)
      @(negedge ref_clk);
    if (n == 5000) n_mismatch++;
    read_var(8'h2a, 32'ha5c3002a);
    read_var(8'hff, 32'ha5c300ff);
    t_outputs();
    t_errors();
    t_refsearch();
    t_nv();
    t_auto(1'b0, 8'h07, 32'hcafe0001);
    t_auto(1'b1, 8'h08, 32'ha5c30008);
    give_verdict();
  end
endmodule // mcd_decoder_tb
bind mcd_decoder mcd_assertions u_chk (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .gp_param_wr(gp_param_wr), .gp_param_volatile(gp_param_volatile), .nv_store(nv_store),
  .nv_load(nv_load), .ref_start(ref_start), .ref_stop(ref_stop),
  .general_output_zero(general_output_zero));
`default_nettype wire
